// ---- pab_pkg.sv ----
package pab_pkg;
   // Pipeline shape
   localparam int STAGES = 4;
   localparam int CODE_W = 4;
   localparam int RAW_W = 16;
   localparam int WORD_W = 12;
   localparam int SUM_W = 14;

   // Timing: one sample period is four mclk cycles (phi1, gap, phi2, gap)
   localparam int MCLK_PERIOD_PS = 4000;
   localparam int MCLK_PER_SAMPLE = 4;
   localparam int OUTPUT_LATENCY = 3;

   // Weight of each stage code in the corrected sum (one redundant bit between stages 0-1 and 1-2, two between stages 2 and 3)
   localparam int STAGE0_SHIFT = 8;
   localparam int STAGE1_SHIFT = 5;
   localparam int STAGE2_SHIFT = 2;

   // Redundancy bias removed after summing the stage codes
   localparam logic [SUM_W-1:0] CORR_BIAS = 14'h0090;
   localparam logic [SUM_W-1:0] CORR_SPAN = 14'h0FFF;

   // Offset binary code points
   localparam logic [WORD_W-1:0] WORD_MAX = 12'hFFF;
   localparam logic [WORD_W-1:0] WORD_MIN = 12'h000;
   localparam logic [WORD_W-1:0] WORD_RESET = 12'h800;

   // Fill counter saturates once the pipeline holds real samples
   localparam logic [1:0] FILL_FULL = 2'h3;
   localparam logic [2:0] TICK_SAT = 3'h7;

   typedef enum logic [1:0] {PAB_PH1, PAB_GAP1, PAB_PH2, PAB_GAP2} pab_phase_t;
endpackage

// ---- pab_delay_line.sv ----
`timescale 1ns/1ps
module pab_delay_line #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 2
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Capture on the stage's own phase, shift on the sampling phase
   input wire logic cap_en,
   input wire logic shift_en,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   import pab_pkg::*;

   generate
      if (WIDTH < 1 || DEPTH < 0)
      begin : g_bad
         $error("pab_delay_line: WIDTH must be at least 1 and DEPTH at least 0");
      end
   endgenerate

   logic [WIDTH-1:0] tap_q [DEPTH+1];
   logic [WIDTH-1:0] tap_d [DEPTH+1];

   always_comb
   begin
      tap_d = tap_q;
      if (cap_en)
      begin
         tap_d[0] = din;
      end
      if (shift_en)
      begin
         for (int i = 1; i <= DEPTH; i++)
         begin
            tap_d[i] = tap_q[i-1];
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         for (int i = 0; i <= DEPTH; i++)
         begin
            tap_q[i] <= '0;
         end
      end
      else
      begin
         tap_q <= tap_d;
      end
   end

   assign dout = tap_q[DEPTH];
endmodule // pab_delay_line

// ---- pab_backend.sv ----
`timescale 1ns/1ps
// Overview of operation
// - A conversion is split over four stages, three giving a 4-bit code plus residue and a last giving a final 4-bit code.
// - A non-overlapping two-phase clock is derived from the sampling clock and sequences sampling and stages.
// - The input sample is taken at the falling edge of the first phase, the second phase holding it.
// - Each stage samples in one phase and amplifies in the other, neighbours running in opposite phase.
// - Each stage code runs through a delay line on the sampling phase so all four codes of a sample align.
// - Error correction folds the aligned 16 raw bits, redundancy included, into one 12-bit word per sample.
// - The word of a sample reaches the data pins on the third clock cycle after that sample is taken.
// - After the initial latency a new word follows on every clock cycle.
// - The word passes two cascaded latches tied to the sampling clock before the pins.
// - The result is offset binary, all ones near plus full scale, all zeros near minus, MSB alone mid-scale.
module pab_backend (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Sampling clock running
   input wire logic clk_run,
   // Stage codes from the flash converters
   input wire logic [pab_pkg::CODE_W-1:0] stage_code_0,
   input wire logic [pab_pkg::CODE_W-1:0] stage_code_1,
   input wire logic [pab_pkg::CODE_W-1:0] stage_code_2,
   input wire logic [pab_pkg::CODE_W-1:0] stage_code_3,
   // Internal two-phase clock
   output logic phi1_q,
   output logic phi2_q,
   output logic sample_strobe_q,
   // Parallel output word
   output logic [pab_pkg::WORD_W-1:0] data_out_q,
   output logic word_strobe_q,
   output logic word_valid_q
);
   import pab_pkg::*;

   pab_phase_t phase_q, phase_d;
   logic phi1_d, phi2_d, sample_strobe_d;
   logic tick1, tick2;
   logic [CODE_W-1:0] code_in [STAGES];
   logic [CODE_W-1:0] aligned [STAGES];
   logic [SUM_W-1:0] raw_sum, corr_diff;
   logic [WORD_W-1:0] corr_word;
   logic [WORD_W-1:0] buf_a_q, buf_a_d, data_out_d;
   logic word_strobe_d, word_valid_d;
   logic [1:0] fill_q, fill_d;

   // Phase ticks mark the falling edge of each phase
   assign tick1 = phi1_q && clk_run;
   assign tick2 = phi2_q && clk_run;

   always_comb
   begin
      phase_d = phase_q;
      if (clk_run)
      begin
         unique case (phase_q)
            PAB_PH1: phase_d = PAB_GAP1;
            PAB_GAP1: phase_d = PAB_PH2;
            PAB_PH2: phase_d = PAB_GAP2;
            PAB_GAP2: phase_d = PAB_PH1;
         endcase
      end
      // Gap states keep the two phases from overlapping
      phi1_d = clk_run && (phase_d == PAB_PH1);
      phi2_d = clk_run && (phase_d == PAB_PH2);
      sample_strobe_d = tick1;
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         phase_q <= PAB_GAP2;
         phi1_q <= 1'b0;
         phi2_q <= 1'b0;
         sample_strobe_q <= 1'b0;
      end
      else
      begin
         phase_q <= phase_d;
         phi1_q <= phi1_d;
         phi2_q <= phi2_d;
         sample_strobe_q <= sample_strobe_d;
      end
   end

   assign code_in[0] = stage_code_0;
   assign code_in[1] = stage_code_1;
   assign code_in[2] = stage_code_2;
   assign code_in[3] = stage_code_3;

   // Even stages resolve at the end of phi2, odd stages at the end of phi1
   genvar k;
   generate
      for (k = 0; k < STAGES; k++)
      begin : g_stage
         pab_delay_line #(
            .WIDTH(CODE_W),
            .DEPTH((STAGES - k) / 2)
         ) u_dly (
            .mclk(mclk),
            .reset_n(reset_n),
            .cap_en((k % 2 == 0) ? tick2 : tick1),
            .shift_en(tick1),
            .din(code_in[k]),
            .dout(aligned[k])
         );
      end
   endgenerate

   // Overlapping weights let a later stage correct an earlier decision
   always_comb
   begin
      raw_sum = SUM_W'({aligned[0], 8'h00} >> (8 - STAGE0_SHIFT))
              + SUM_W'({aligned[1], 5'h00} >> (5 - STAGE1_SHIFT))
              + SUM_W'({aligned[2], 2'h0} >> (2 - STAGE2_SHIFT))
              + SUM_W'(aligned[3]);
      corr_diff = raw_sum - CORR_BIAS;
      if (raw_sum < CORR_BIAS)
      begin
         corr_word = WORD_MIN;
      end
      else if (corr_diff > CORR_SPAN)
      begin
         corr_word = WORD_MAX;
      end
      else
      begin
         corr_word = corr_diff[WORD_W-1:0];
      end
   end

   // Latch A on phi2, latch B on the next phi1 fall drives the pins
   always_comb
   begin
      buf_a_d = tick2 ? corr_word : buf_a_q;
      data_out_d = tick1 ? buf_a_q : data_out_q;
      fill_d = fill_q;
      word_valid_d = word_valid_q;
      word_strobe_d = 1'b0;
      if (!clk_run)
      begin
         fill_d = 2'h0;
         word_valid_d = 1'b0;
      end
      else if (tick1)
      begin
         if (fill_q == FILL_FULL)
         begin
            word_valid_d = 1'b1;
            word_strobe_d = 1'b1;
         end
         else
         begin
            fill_d = fill_q + 2'h1;
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         buf_a_q <= WORD_RESET;
         data_out_q <= WORD_RESET;
         fill_q <= 2'h0;
         word_valid_q <= 1'b0;
         word_strobe_q <= 1'b0;
      end
      else
      begin
         buf_a_q <= buf_a_d;
         data_out_q <= data_out_d;
         fill_q <= fill_d;
         word_valid_q <= word_valid_d;
         word_strobe_q <= word_strobe_d;
      end
   end

   // Helper counters for the checks
   logic [2:0] run_age_q, run_age_d, tick_cnt_q, tick_cnt_d;
   always_comb
   begin
      run_age_d = (run_age_q == TICK_SAT) ? run_age_q : run_age_q + 3'h1;
      tick_cnt_d = (tick1 && tick_cnt_q != TICK_SAT) ? tick_cnt_q + 3'h1 : tick_cnt_q;
      if (!clk_run)
      begin
         run_age_d = 3'h0;
         tick_cnt_d = 3'h0;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         run_age_q <= 3'h0;
         tick_cnt_q <= 3'h0;
      end
      else
      begin
         run_age_q <= run_age_d;
         tick_cnt_q <= tick_cnt_d;
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!reset_n);

   sequence s_gap_then_phi2;
      (!phi1_q && !phi2_q) ##1 phi2_q;
   endsequence

   sequence s_phi1_fall;
      tick1 ##1 clk_run;
   endsequence

   chk_final_flash: assert property (tick1 |=> aligned[3] == $past(stage_code_3))
      else $error("final stage code not taken straight on the phi1 fall");
   chk_phase_nonoverlap: assert property (!(phi1_q && phi2_q) and (s_phi1_fall |-> s_gap_then_phi2))
      else $error("phases overlap or skip the gap");
   chk_sample_edge: assert property (sample_strobe_q |-> $fell(phi1_q) && !phi2_q)
      else $error("sample strobe not at the phi1 fall");
   chk_stage_alternate: assert property (tick1 ##1 clk_run ##1 clk_run |-> tick2)
      else $error("stage phases do not alternate");
   chk_delay_align: assert property (tick1 && run_age_q == TICK_SAT |=> aligned[0] == $past(stage_code_0, 7)
         && aligned[1] == $past(stage_code_1, 5) && aligned[2] == $past(stage_code_2, 3))
      else $error("stage codes not aligned for one sample");
   chk_corr_path: assert property (tick2 ##1 clk_run ##1 clk_run |-> ##1 data_out_q == $past(corr_word, 3))
      else $error("corrected word not carried to the pins");
   chk_latency_fill: assert property ($rose(word_valid_q) |-> tick_cnt_q == 3'h4)
      else $error("first valid word not on the third cycle after the first sample");
   chk_word_rate: assert property (word_valid_q && tick1 |=> word_strobe_q ##1 !word_strobe_q)
      else $error("no new word in a sampling cycle");
   chk_output_latch: assert property ($changed(data_out_q) |-> $past(tick1) && data_out_q == $past(buf_a_q))
      else $error("pins changed outside the second latch");
   chk_offset_clamp: assert property ((raw_sum < CORR_BIAS |-> corr_word == WORD_MIN)
         and (raw_sum > CORR_BIAS + CORR_SPAN |-> corr_word == WORD_MAX)
         and (raw_sum == CORR_BIAS + WORD_RESET |-> corr_word == WORD_RESET))
      else $error("offset binary coding wrong at an end or mid-scale");
endmodule // pab_backend

// ---- pab_capture_model.sv ----
`timescale 1ns/1ps
module pab_capture_model (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset_n,
   // Parallel output word
   input wire logic [pab_pkg::WORD_W-1:0] data_out_q,
   input wire logic word_strobe_q,
   input wire logic word_valid_q,
   // Captured words
   output logic [pab_pkg::WORD_W-1:0] cap_word,
   output int cap_count
);
   import pab_pkg::*;
   // Fill words seen before validity are dropped
   always @(posedge mclk)
   begin
      if (!reset_n || !word_valid_q)
      begin
         cap_count <= 0;
      end
      else if (word_strobe_q)
      begin
         cap_word <= data_out_q;
         cap_count <= cap_count + 1;
      end
   end
endmodule // pab_capture_model

// ---- pab_backend_tb_top.sv ----
`timescale 1ns/1ps
module pab_backend_tb_top;
   import pab_pkg::*;
   logic mclk, reset_n, clk_run, phi1_q, phi2_q, sample_strobe_q, word_strobe_q, word_valid_q;
   logic [CODE_W-1:0] sc0, sc1, sc2, sc3;
   logic [WORD_W-1:0] data_out_q, cap_word;
   int cap_count, n_errors, samples_checked, cycles, m;
   logic [15:0] tbl [8] = '{16'h0000, 16'hFFFF, 16'h8440, 16'h1234, 16'hA5C3, 16'h7F09, 16'h0490, 16'h47E0};

   pab_backend dut_u (.mclk(mclk), .reset_n(reset_n), .clk_run(clk_run), .stage_code_0(sc0),
      .stage_code_1(sc1), .stage_code_2(sc2), .stage_code_3(sc3), .phi1_q(phi1_q), .phi2_q(phi2_q),
      .sample_strobe_q(sample_strobe_q), .data_out_q(data_out_q), .word_strobe_q(word_strobe_q),
      .word_valid_q(word_valid_q));
   pab_capture_model cap_u (.mclk(mclk), .reset_n(reset_n), .data_out_q(data_out_q),
      .word_strobe_q(word_strobe_q), .word_valid_q(word_valid_q), .cap_word(cap_word), .cap_count(cap_count));

   function automatic logic [3:0] cd(input int k, input int n);
      logic [15:0] c;
      c = tbl[n & 7];
      return c[15 - 4 * k -: 4];
   endfunction

   // Corrected offset binary word for sample n
   function automatic logic [WORD_W-1:0] exp_word(input int n);
      int s;
      s = cd(0, n) * 256 + cd(1, n) * 32 + cd(2, n) * 4 + cd(3, n) - 144;
      if (s < 0)
         return 12'h000;
      if (s > 4095)
         return 12'hFFF;
      return s[11:0];
   endfunction

   initial
   begin
      mclk = 0;
      forever #2 mclk = ~mclk;
   end

   // Stage codes are valid only in their capture phase, inverted elsewhere
   // Sample count advances once the design reports a sample taken
   always @(posedge mclk)
   begin
      if (!clk_run || !reset_n)
         m = 0;
      #1;
      if (sample_strobe_q)
         m++;
      sc0 = phi2_q ? cd(0, m - 1) : ~cd(0, m - 1);
      sc2 = phi2_q ? cd(2, m - 2) : ~cd(2, m - 2);
      sc1 = phi1_q ? cd(1, m - 1) : ~cd(1, m - 1);
      sc3 = phi1_q ? cd(3, m - 2) : ~cd(3, m - 2);
   end

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_errors++;
         wrap_up;
      end
   end

   task automatic step;
      @(posedge mclk);
      #1;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic t_reset;
      chk("phi1", 0, phi1_q);
      chk("phi2", 0, phi2_q);
      chk("reset word", 16'h0800, data_out_q);
      chk("valid", 0, word_valid_q);
      $display("test reset done");
   endtask

   task automatic t_stream;
      int t;
      step;
      chk("phi1 first", 1, phi1_q);
      step;
      chk("sample strobe", 1, sample_strobe_q);
      chk("phi1 low", 0, phi1_q);
      step;
      chk("phi2", 1, phi2_q);
      t = 2;
      while (word_strobe_q !== 1'b1 && t < 40)
      begin
         step;
         t++;
      end
      chk("latency", OUTPUT_LATENCY * MCLK_PER_SAMPLE + 1, t[15:0]);
      chk("valid", 1, word_valid_q);
      for (int k = 0; k < 12; k++)
      begin
         chk("word", exp_word(k), data_out_q);
         repeat (4) step;
         chk("strobe", 1, word_strobe_q);
      end
      chk("captured", 12, cap_count[15:0]);
      chk("last capture", exp_word(11), cap_word);
      $display("test stream done");
   endtask

   task automatic t_abort;
      logic [1:0] ph;
      int t;
      clk_run = 0;
      step;
      ph = {phi1_q, phi2_q};
      repeat (3) step;
      chk("phase hold", ph, {phi1_q, phi2_q});
      chk("valid cleared", 0, word_valid_q);
      clk_run = 1;
      step;
      chk("resume phi2", 1, phi2_q);
      t = 0;
      while (word_strobe_q !== 1'b1 && t < 40)
      begin
         step;
         t++;
      end
      // Resuming from the held gap costs two cycles (phi2, then the gap) before the first phi1
      chk("restart latency", OUTPUT_LATENCY * MCLK_PER_SAMPLE + 3, t[15:0]);
      for (int k = 0; k < 4; k++)
      begin
         chk("restart word", exp_word(k), data_out_q);
         repeat (4) step;
      end
      $display("test abort done");
   endtask

   // Reset while running, then the full stream again from scratch
   task automatic t_midreset;
      reset_n = 0;
      repeat (4) step;
      t_reset;
      reset_n = 1;
      t_stream;
      $display("test midreset done");
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      reset_n = 0;
      clk_run = 0;
      n_errors = 0;
      samples_checked = 0;
      cycles = 0;
      repeat (16) @(posedge mclk);
      #1;
      t_reset;
      reset_n = 1;
      clk_run = 1;
      t_stream;
      t_abort;
      t_midreset;
      wrap_up;
   end
endmodule // pab_backend_tb_top
